// File: pkg/lp_pkg.sv
// Purpose: shared constants and types for the core low-power handshake
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: ratios are held doubled so that 2.5:1 fits an integer
package lp_pkg;

  // =====================================================
  // Timing and encodings
  localparam int CLK_MHZ = 100;
  localparam int GATE_LIMIT_SYS_CLKS = 4;
  localparam int SNOOP_MIN_CORE_CYCLES = 5;
  localparam logic [5:0] PLL_OFF_CFG = 6'h3c;
  localparam logic [5:0] MIN_RATIO_X2 = 6'h04;
  localparam logic [5:0] LOW_RATIO_X2 = 6'h06;
  localparam logic [5:0] SNOOP_RATIO_X2 = 6'h0a;
  localparam int INIT_CORE_CYCLES = 32;
  localparam int HRESET_HOLD_CYCLES = 16;

  // =====================================================
  // Controller register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PLLCFG_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam int CTRL_ARM_BIT = 0;
  localparam int CTRL_PLLOFF_BIT = 1;
  localparam int CTRL_HALVE_BIT = 2;
  localparam int CTRL_QUARTER_BIT = 3;
  localparam int CTRL_HRESET_BIT = 4;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [5:0] PLLCFG_RESET = 6'h10;

  // =====================================================
  // State machines
  typedef enum logic [2:0] {
    CS_FULL, CS_QUIESCING, CS_QUIESCED, CS_GATED_LIGHT, CS_GATED_DEEP,
    CS_PLL_OFF, CS_INIT
  } core_state_type;

  typedef enum logic [2:0] {
    HS_IDLE, HS_QUIESCE, HS_GATE, HS_PLL_OFF, HS_HRESET, HS_RELEASE
  } host_state_type;

  // Address-acknowledge delay in bus cycles for a doubled ratio
  function automatic logic [1:0] ack_delay_need(input logic [5:0] ratio_x2);
    if (ratio_x2 < LOW_RATIO_X2) begin
      return 2'h2;
    end else if (ratio_x2 < SNOOP_RATIO_X2) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : ack_delay_need

endpackage : lp_pkg

// File: pkg/lp_if.sv
// Purpose: link between core low-power logic and device power logic
// Assumes: both ends on clk_i; active-low pins named with _n
// Notes: no tri-state pins on this link
`timescale 1ns/1ns
interface lp_if;
  logic light_req;
  logic deep_req;
  logic quiesce_done;
  logic clocks_gated;
  logic [1:0] ack_delay;
  logic quiesce_req;
  logic gate_req;
  logic int_n;
  logic smi_n;
  logic sreset_n;
  logic mcp_n;
  logic hreset_n;
  logic [5:0] pll_cfg;
  logic hw_halve_ratio_n;
  logic hw_quarter_ratio_n;

  // =====================================================
  // Core end
  modport core (
    output light_req, deep_req, quiesce_done, clocks_gated, ack_delay,
    input quiesce_req, gate_req, int_n, smi_n, sreset_n, mcp_n, hreset_n,
    input pll_cfg, hw_halve_ratio_n, hw_quarter_ratio_n
  );

  // =====================================================
  // Device power-management end
  modport pmu (
    input light_req, deep_req, quiesce_done, clocks_gated, ack_delay,
    output quiesce_req, gate_req, int_n, smi_n, sreset_n, mcp_n, hreset_n,
    output pll_cfg, hw_halve_ratio_n, hw_quarter_ratio_n
  );
endinterface : lp_if

// File: logic/core_lowpower_handshake.sv
// Purpose: core-side sleep/deep-sleep handshake and frequency switching
// Assumes: clk_i is the bus-rate reference; core clock is an enable pulse
// Notes: ratios held doubled; both hw ratio pins low forces switching off
//
// Contract
// RL1 - Deep gated: all clocks stopped, no snoop, PLL on; here core_tick_o keeps pulsing in the deep gated state
// RL2 - Deep gate takes effect within four clocks
// RL3 - Gate request held; quiesce-done stays asserted
// RL4 - Interrupt, smi, soft reset, check wake; decrementer not; here the decrementer also wakes from quiesced and light gating
// RL5 - Full power drops quiesce-done and clocks-gated
// RL6 - Hard reset exits deep state, then initialisation
// RL7 - Deep: snoop off, gate release ignored
// RL8 - Host drives PLL-off code to power PLL down
// RL9 - PLL-off left only by ordered hard reset
// RL10 - Requests need enable plus matching select bit
// RL11 - Light select gates clocks, time base runs
// RL12 - Deep select stops time base when gated
// RL13 - Host watches interrupts, drops gate and quiesce
// RL14 - Leaving low power clears enable bit, no restore
// RL15 - Host tolerates requests lingering after wake
// RL16 - Divide bits halve or quarter ratio in one cycle
// RL17 - Ratio never below 2:1, usable across states
// RL18 - Active-low pins select halve/quarter or force off
// RL19 - Snoop answer needs five core cycles
// RL20 - Host delays acknowledge by ratio table
// RL21 - Delay added before switching, removed after clearing; host delay here follows the ratio change one cycle later
// RL22 - Clocks-gated output whenever unit clocks stop; idle-unit gating and init stop them with it low
// RL23 - Quiesce: stop fetch, drain, then quiesce-done
// RL24 - Gate request ignored until quiesce-done
`timescale 1ns/1ns
module core_lowpower_handshake
  import lp_pkg::*;
#(
  parameter logic [5:0] BASE_RATIO_X2 = 6'h10,
  parameter int INIT_CYCLES = INIT_CORE_CYCLES
) (
  input wire logic clk_i, // Reference clock
  input wire logic rst_i, // Synchronous reset
  lp_if.core lp, // Link to device power logic
  input wire logic powerdown_enable_set_i, // Software sets enable bit
  input wire logic light_lowpower_select_i, // Light state chosen
  input wire logic deep_lowpower_select_i, // Deep state chosen
  input wire logic idle_unit_gating_enable_i, // Idle unit gating
  input wire logic [1:0] freq_divide_bits_i, // [0] halve, [1] quarter
  input wire logic pipeline_empty_i, // Core pipeline drained
  input wire logic dec_irq_i, // Decrementer event
  output logic powerdown_enable_bit_o, // Enable bit value
  output logic fetch_stop_o, // Instruction fetch held
  output logic core_tick_o, // Core clock enable
  output logic unit_clk_en_o, // Functional unit clock enable
  output logic timebase_en_o, // Time base and decrementer enable
  output logic snoop_en_o, // Snoop processing allowed
  output logic pll_run_o, // PLL locked and running
  output logic [5:0] core_ratio_x2_o // Effective ratio, doubled
);

  // =====================================================
  // State record
  typedef struct packed {
    core_state_type st;
    logic pde;
    logic [2:0] div_cnt;
    logic [1:0] shift;
    logic [15:0] init_cnt;
    logic qdone;
    logic gated;
    logic lreq;
    logic dreq;
    logic [1:0] need;
    logic [5:0] ratio;
  } core_regs_type;

  core_regs_type q;
  core_regs_type d;

  // Largest allowed shift not dropping under 2:1
  function automatic logic [1:0] clamp_shift(input logic [1:0] want);
    if ((BASE_RATIO_X2 >> want) >= MIN_RATIO_X2) begin
      return want;
    end else if (want == 2'h2 && (BASE_RATIO_X2 >> 1) >= MIN_RATIO_X2) begin
      return 2'h1;
    end
    return 2'h0;
  endfunction : clamp_shift

  logic wake;
  logic hw_off;
  logic div4;
  logic div2;
  logic [1:0] shift_want;
  logic tick;
  logic in_low;

  // Wake sources and divider selection
  always_comb begin
    wake = ~lp.int_n | ~lp.smi_n | ~lp.sreset_n | ~lp.mcp_n; // RL4
    hw_off = ~lp.hw_halve_ratio_n & ~lp.hw_quarter_ratio_n; // RL18
    div4 = ~hw_off & (freq_divide_bits_i[1] | ~lp.hw_quarter_ratio_n); // RL18
    div2 = ~hw_off & ~div4 & (freq_divide_bits_i[0] | ~lp.hw_halve_ratio_n);
    if (div4) begin
      shift_want = clamp_shift(2'h2); // RL17
    end else if (div2) begin
      shift_want = clamp_shift(2'h1); // RL16
    end else begin
      shift_want = 2'h0;
    end
    tick = (q.div_cnt == 3'h0) && (q.st != CS_PLL_OFF);
    in_low = (q.st == CS_QUIESCED) || (q.st == CS_GATED_LIGHT) ||
             (q.st == CS_GATED_DEEP);
  end

  // Next-state logic
  always_comb begin
    d = q;
    // New ratio applies from the next cycle, no idle gap
    d.shift = shift_want; // RL16
    d.ratio = BASE_RATIO_X2 >> shift_want; // RL17
    if (shift_want != q.shift) begin
      d.div_cnt = 3'h0; // RL16
    end else if (q.div_cnt == ((3'h1 << q.shift) - 3'h1)) begin
      d.div_cnt = 3'h0;
    end else begin
      d.div_cnt = q.div_cnt + 3'h1;
    end
    d.need = ack_delay_need(d.ratio); // RL19
    case (q.st)
      CS_FULL: begin
        if (lp.quiesce_req) begin
          d.st = CS_QUIESCING; // RL23
        end
      end
      CS_QUIESCING: begin
        if (!lp.quiesce_req) begin
          d.st = CS_FULL;
        end else if (pipeline_empty_i) begin
          d.st = CS_QUIESCED; // RL23
          d.qdone = 1'b1; // RL23
        end
      end
      CS_QUIESCED: begin
        if (wake || dec_irq_i || !lp.quiesce_req) begin
          d.st = CS_FULL;
        end else if (lp.gate_req) begin
          // Only reached with quiesce-done high
          d.st = deep_lowpower_select_i ? CS_GATED_DEEP : CS_GATED_LIGHT; // RL24
          d.gated = 1'b1; // RL22 RL2
        end
      end
      CS_GATED_LIGHT: begin
        if (wake || dec_irq_i) begin
          d.st = CS_FULL; // RL4
        end else if (!lp.gate_req) begin
          d.st = CS_QUIESCED; // Snoop window
          d.gated = 1'b0;
        end
      end
      CS_GATED_DEEP: begin
        // Gate release ignored; decrementer is stopped here
        if (wake) begin
          d.st = CS_FULL; // RL4 RL7
        end else if (lp.pll_cfg == PLL_OFF_CFG) begin
          d.st = CS_PLL_OFF; // RL8
        end
      end
      CS_PLL_OFF: begin
        d.st = CS_PLL_OFF; // RL9
      end
      CS_INIT: begin
        if (q.init_cnt == 16'h0000) begin
          d.st = CS_FULL; // RL6
        end else begin
          d.init_cnt = q.init_cnt - 16'h0001;
        end
      end
      default: begin
        d.st = CS_FULL;
      end
    endcase
    // Return to full power drops both handshake outputs
    if (in_low && d.st == CS_FULL) begin
      d.qdone = 1'b0; // RL5
      d.gated = 1'b0; // RL5
      d.pde = 1'b0; // RL14
    end
    if (q.st == CS_QUIESCING && d.st == CS_FULL) begin
      d.pde = 1'b0; // RL14
    end
    // Set wins over a same-cycle wake clear; hard reset below still clears it
    if (powerdown_enable_set_i) begin
      d.pde = 1'b1;
    end
    // Hard reset leaves any state, even PLL-off
    if (!lp.hreset_n) begin
      d.st = CS_INIT; // RL6 RL9
      d.init_cnt = 16'(INIT_CYCLES);
      d.pde = 1'b0;
      d.qdone = 1'b0;
      d.gated = 1'b0;
    end
    d.lreq = d.pde & light_lowpower_select_i & ~deep_lowpower_select_i; // RL10
    d.dreq = d.pde & deep_lowpower_select_i; // RL10
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: CS_FULL, pde: 1'b0, div_cnt: 3'h0, shift: 2'h0,
             init_cnt: 16'h0000, qdone: 1'b0, gated: 1'b0, lreq: 1'b0,
             dreq: 1'b0, need: 2'h0, ratio: BASE_RATIO_X2};
    end else begin
      q <= d;
    end
  end

  // =====================================================
  // Link outputs
  assign lp.light_req = q.lreq; // RL10
  assign lp.deep_req = q.dreq; // RL10
  assign lp.quiesce_done = q.qdone; // RL3
  assign lp.clocks_gated = q.gated; // RL22
  assign lp.ack_delay = q.need; // RL19

  // =====================================================
  // Core-side enables
  always_comb begin
    powerdown_enable_bit_o = q.pde;
    fetch_stop_o = (q.st != CS_FULL); // RL23
    core_tick_o = tick;
    unit_clk_en_o = tick && !q.gated && (q.st != CS_INIT) &&
                    !(idle_unit_gating_enable_i && pipeline_empty_i); // RL1
    timebase_en_o = tick && (q.st != CS_GATED_DEEP) &&
                    (q.st != CS_INIT); // RL11 RL12
    snoop_en_o = (q.st == CS_FULL) || (q.st == CS_QUIESCING) ||
                 (q.st == CS_QUIESCED); // RL7 RL1
    pll_run_o = (q.st != CS_PLL_OFF); // RL1
    core_ratio_x2_o = q.ratio;
  end

endmodule : core_lowpower_handshake

// File: logic/device_power_manager.sv
// Purpose: device power logic answering core low-power requests
// Assumes: classic Wishbone slave, one-cycle acknowledge
// Notes: interrupts are forwarded and also end any gated state except PLL-off
`timescale 1ns/1ns
module device_power_manager
  import lp_pkg::*;
#(
  parameter int HRESET_CYCLES = HRESET_HOLD_CYCLES
) (
  input wire logic clk_i, // Reference clock
  input wire logic rst_i, // Synchronous reset
  lp_if.pmu lp, // Link to core
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic ext_int_i, // External interrupt request
  input wire logic smi_i, // System management interrupt
  input wire logic sreset_i, // Soft reset request
  input wire logic mcp_i, // Machine check
  input wire logic snoop_req_i, // Bus wants to snoop core
  output logic [1:0] aack_delay_o // Address acknowledge delay
);

  // =====================================================
  // State record
  typedef struct packed {
    host_state_type st;
    logic [3:0] ctrl;
    logic [5:0] pllcfg;
    logic quiesce;
    logic gate;
    logic deep;
    logic [5:0] cfg_out;
    logic [15:0] cnt;
    logic hreset_n;
    logic [1:0] delay;
    logic ack;
    logic [31:0] rdata;
  } host_regs_type;

  host_regs_type q;
  host_regs_type d;
  logic irq;
  logic wr;
  logic hreset_go;

  // Next-state logic
  always_comb begin
    d = q;
    irq = ext_int_i | smi_i | sreset_i | mcp_i;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & ~q.ack & wb_sel_i[0];
    hreset_go = wr && (wb_adr_i == CTRL_OFS) && wb_dat_i[CTRL_HRESET_BIT];
    // Bus slave: one-cycle answer, unmapped reads as zero
    d.ack = wb_cyc_i & wb_stb_i & ~q.ack;
    d.rdata = 32'h0000_0000;
    case (wb_adr_i)
      CTRL_OFS: d.rdata[3:0] = q.ctrl;
      PLLCFG_OFS: d.rdata[5:0] = q.pllcfg;
      STATUS_OFS: d.rdata = {20'h00000, 1'(q.st), q.delay, q.hreset_n,
                             lp.clocks_gated, lp.quiesce_done,
                             lp.deep_req, lp.light_req, 1'b0, 3'(q.st)};
      default: d.rdata = 32'h0000_0000;
    endcase
    if (wr && wb_adr_i == CTRL_OFS) begin
      d.ctrl = wb_dat_i[3:0];
    end
    if (wr && wb_adr_i == PLLCFG_OFS) begin
      d.pllcfg = wb_dat_i[5:0];
    end
    // Delay grows at once, shrinks only when switching is off
    if (lp.ack_delay > q.delay || lp.ack_delay == 2'h0) begin
      d.delay = lp.ack_delay; // RL20 RL21
    end
    case (q.st)
      HS_IDLE: begin
        d.cfg_out = q.pllcfg;
        if (q.ctrl[CTRL_ARM_BIT] && (lp.light_req || lp.deep_req) && !irq) begin
          d.st = HS_QUIESCE;
          d.quiesce = 1'b1;
          d.deep = lp.deep_req;
        end
      end
      HS_QUIESCE: begin
        if (irq) begin
          d.st = HS_RELEASE; // RL13
        end else if (lp.quiesce_done) begin
          d.st = HS_GATE;
          d.gate = 1'b1; // RL24
        end
      end
      HS_GATE: begin
        // Gate held for the whole stay; light mode opens snoop windows
        d.gate = !(!q.deep && snoop_req_i); // RL3
        if (irq) begin
          d.st = HS_RELEASE; // RL13
        end else if (q.deep && q.ctrl[CTRL_PLLOFF_BIT] && lp.clocks_gated) begin
          d.st = HS_PLL_OFF;
          d.cfg_out = PLL_OFF_CFG; // RL8
        end
      end
      HS_PLL_OFF: begin
        d.st = HS_PLL_OFF; // RL9
      end
      HS_HRESET: begin
        // Configuration restored a cycle before reset asserts
        d.hreset_n = 1'b0; // RL9
        d.quiesce = 1'b0;
        d.gate = 1'b0;
        if (q.cnt == 16'h0000) begin
          d.st = HS_RELEASE;
          d.hreset_n = 1'b1;
        end else begin
          d.cnt = q.cnt - 16'h0001;
        end
      end
      HS_RELEASE: begin
        // Requests may linger until the core services the wake
        if (!lp.quiesce_done && !lp.clocks_gated && !lp.light_req &&
            !lp.deep_req) begin
          d.st = HS_IDLE; // RL15
        end
      end
      default: begin
        d.st = HS_IDLE;
      end
    endcase
    if (d.st == HS_RELEASE) begin
      d.quiesce = 1'b0; // RL13
      d.gate = 1'b0; // RL13
    end
    if (hreset_go && q.st != HS_HRESET) begin
      d.st = HS_HRESET; // RL9
      d.cfg_out = q.pllcfg; // RL9
      d.cnt = 16'(HRESET_CYCLES);
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '{st: HS_IDLE, ctrl: CTRL_RESET, pllcfg: PLLCFG_RESET,
             quiesce: 1'b0, gate: 1'b0, deep: 1'b0, cfg_out: PLLCFG_RESET,
             cnt: 16'h0000, hreset_n: 1'b1, delay: 2'h0, ack: 1'b0,
             rdata: 32'h0000_0000};
    end else begin
      q <= d;
    end
  end

  // =====================================================
  // Outputs
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdata;
  assign aack_delay_o = q.delay; // RL20
  assign lp.quiesce_req = q.quiesce;
  assign lp.gate_req = q.gate;
  assign lp.int_n = ~ext_int_i;
  assign lp.smi_n = ~smi_i;
  assign lp.sreset_n = ~sreset_i;
  assign lp.mcp_n = ~mcp_i;
  assign lp.hreset_n = q.hreset_n;
  assign lp.pll_cfg = q.cfg_out;
  assign lp.hw_halve_ratio_n = ~q.ctrl[CTRL_HALVE_BIT]; // RL18
  assign lp.hw_quarter_ratio_n = ~q.ctrl[CTRL_QUARTER_BIT]; // RL18

endmodule : device_power_manager

// File: verification/lp_link_properties.sv
// Purpose: link assertions for the low-power handshake
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the signals between the two ends
`timescale 1ns/1ns
module lp_link_properties
  import lp_pkg::*;
#(
  parameter int HRESET_CYCLES = HRESET_HOLD_CYCLES
) (
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic light_req, // Light request
  input wire logic deep_req, // Deep request
  input wire logic quiesce_done, // Core drained
  input wire logic clocks_gated, // Core clocks off
  input wire logic [1:0] ack_delay, // Delay need
  input wire logic quiesce_req, // Quiesce order
  input wire logic gate_req, // Gate order
  input wire logic int_n, // Interrupt
  input wire logic smi_n, // Management interrupt
  input wire logic sreset_n, // Soft reset
  input wire logic mcp_n, // Machine check
  input wire logic hreset_n, // Hard reset
  input wire logic [5:0] pll_cfg, // PLL setting
  input wire logic hw_halve_ratio_n, // Halve pin
  input wire logic hw_quarter_ratio_n // Quarter pin
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ====================
  // Helpers
  logic wake;
  logic calm;
  logic off_q; // PLL-off seen, until hard reset
  logic [7:0] low_q; // Hard reset low length
  assign wake = !(int_n && smi_n && sreset_n && mcp_n);
  assign calm = hreset_n && !off_q && (pll_cfg != PLL_OFF_CFG);

  // Track PLL-off and hard reset length
  always_ff @(posedge clk_i) begin
    if (rst_i || !hreset_n) begin
      off_q <= 1'b0;
    end else if (clocks_gated && pll_cfg == PLL_OFF_CFG) begin
      off_q <= 1'b1;
    end
    low_q <= hreset_n ? 8'h00 : low_q + 8'h01;
  end

  // ====================
  // Assertions
  a_gate_after_done: assert property ($rose(clocks_gated) |-> $past(quiesce_done) &&
    $past(gate_req)) else $error("gated without quiesce-done");
  a_gate_in_four: assert property (quiesce_done && gate_req && !clocks_gated && !wake && calm
    |-> ##[1:4] (clocks_gated || !gate_req || wake)) else $error("gating too slow");
  a_wake_to_full: assert property (wake && quiesce_done && calm
    |=> !quiesce_done && !clocks_gated) else $error("no wake on interrupt");
  a_deep_holds: assert property (clocks_gated && deep_req && !wake && calm |=> clocks_gated)
    else $error("deep gating left");
  a_gated_keeps_done: assert property (clocks_gated && calm |-> quiesce_done)
    else $error("quiesce-done dropped while gated");
  a_hreset_clears: assert property (!hreset_n |=> !quiesce_done && !clocks_gated)
    else $error("hard reset kept state");
  a_hreset_length: assert property ($rose(hreset_n) |-> low_q >= HRESET_CYCLES)
    else $error("hard reset too short");
  a_cfg_restored: assert property ($fell(hreset_n) |-> pll_cfg != PLL_OFF_CFG)
    else $error("hard reset with PLL off code");
  a_irq_ends_gate: assert property ($fell(int_n) && gate_req |=> !gate_req && !quiesce_req)
    else $error("requests kept after interrupt");
  a_one_request: assert property (!(light_req && deep_req))
    else $error("both requests high");
endmodule : lp_link_properties

// File: verification/core_lowpower_handshake_tb_top.sv
// Purpose: bench for both ends of the low-power link
// Assumes: 100 MHz clock, 3-cycle reset
// Notes: short hard-reset and init counts
`timescale 1ns/1ns
module core_lowpower_handshake_tb_top;
  import lp_pkg::*;
  localparam int INIT_N = 4;
  localparam int HR_N = 4;
  logic clk_i, rst_i, pd_set, light_sel, deep_sel, idle_gate, pipe_empty, dec_irq, snoop_req;
  logic wb_cyc, wb_stb, wb_we, wb_ack, pd_bit, fetch_stop, tick, unit_en, tb_en, snoop_en;
  logic pll_run;
  logic [1:0] div_bits, aack;
  logic [3:0] wake_q, wb_sel;
  logic [5:0] ratio;
  logic [7:0] wb_adr;
  logic [31:0] wb_dat_w, wb_dat_r;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  // ====================
  // Ends and checker
  lp_if lp_if_inst ();
  core_lowpower_handshake #(.INIT_CYCLES(INIT_N)) core_lowpower_handshake_inst (
    .clk_i(clk_i), .rst_i(rst_i), .lp(lp_if_inst), .powerdown_enable_set_i(pd_set),
    .light_lowpower_select_i(light_sel), .deep_lowpower_select_i(deep_sel),
    .idle_unit_gating_enable_i(idle_gate), .freq_divide_bits_i(div_bits),
    .pipeline_empty_i(pipe_empty), .dec_irq_i(dec_irq), .powerdown_enable_bit_o(pd_bit),
    .fetch_stop_o(fetch_stop), .core_tick_o(tick), .unit_clk_en_o(unit_en),
    .timebase_en_o(tb_en), .snoop_en_o(snoop_en), .pll_run_o(pll_run), .core_ratio_x2_o(ratio));
  device_power_manager #(.HRESET_CYCLES(HR_N)) device_power_manager_inst (
    .clk_i(clk_i), .rst_i(rst_i), .lp(lp_if_inst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .ext_int_i(wake_q[0]), .smi_i(wake_q[1]),
    .sreset_i(wake_q[2]), .mcp_i(wake_q[3]), .snoop_req_i(snoop_req), .aack_delay_o(aack));
  lp_link_properties #(.HRESET_CYCLES(HR_N)) lp_link_properties_inst (
    .clk_i(clk_i), .rst_i(rst_i), .light_req(lp_if_inst.light_req),
    .deep_req(lp_if_inst.deep_req), .quiesce_done(lp_if_inst.quiesce_done),
    .clocks_gated(lp_if_inst.clocks_gated), .ack_delay(lp_if_inst.ack_delay),
    .quiesce_req(lp_if_inst.quiesce_req), .gate_req(lp_if_inst.gate_req),
    .int_n(lp_if_inst.int_n), .smi_n(lp_if_inst.smi_n), .sreset_n(lp_if_inst.sreset_n),
    .mcp_n(lp_if_inst.mcp_n), .hreset_n(lp_if_inst.hreset_n), .pll_cfg(lp_if_inst.pll_cfg),
    .hw_halve_ratio_n(lp_if_inst.hw_halve_ratio_n),
    .hw_quarter_ratio_n(lp_if_inst.hw_quarter_ratio_n));

  // ====================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string s);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: %s got %0h exp %0h", $time, s, got, exp);
    end
  endtask : check

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  // Classic single Wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] r);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_sel <= s;
    wb_dat_w <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    r = wb_dat_r;
    check(wb_ack, 1'b1, "ack");
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, 4'hf, r);
    check(r, e, s);
  endtask : rchk

  // Request, quiesce and gate one state
  task automatic enter(input logic deep, input logic [31:0] ctl);
    logic [31:0] r;
    int i;
    pipe_empty <= 1'b0;
    light_sel <= !deep;
    deep_sel <= deep;
    step(2);
    check(lp_if_inst.light_req | lp_if_inst.deep_req, 1'b0, "no enable");
    pd_set <= 1'b1;
    step(1);
    pd_set <= 1'b0;
    step(2);
    check(deep ? lp_if_inst.deep_req : lp_if_inst.light_req, 1'b1, "request");
    wb(1'b1, CTRL_OFS, ctl, 4'h1, r);
    for (i = 0; i < 20 && lp_if_inst.quiesce_req !== 1'b1; i++) step(1);
    step(3);
    check(fetch_stop, 1'b1, "fetch held");
    check(lp_if_inst.quiesce_done, 1'b0, "busy");
    pipe_empty <= 1'b1;
    for (i = 0; i < 20 && lp_if_inst.clocks_gated !== 1'b1; i++) step(1);
    check(lp_if_inst.clocks_gated, 1'b1, "gated");
  endtask : enter

  // ====================
  // Scenarios
  task automatic t_regs();
    logic [31:0] r;
    rchk(CTRL_OFS, 32'h0, "ctrl");
    rchk(STATUS_OFS, 32'h100, "status");
    rchk(8'h0c, 32'h0, "unmapped");
    wb(1'b1, PLLCFG_OFS, 32'h22, 4'h0, r);
    rchk(PLLCFG_OFS, 32'h10, "sel refused");
    wb(1'b1, PLLCFG_OFS, 32'h22, 4'h1, r);
    rchk(PLLCFG_OFS, 32'h22, "cfg write");
    wb(1'b1, PLLCFG_OFS, 32'h10, 4'h1, r);
    check(lp_if_inst.hw_halve_ratio_n, 1'b1, "pin idle");
    idle_gate <= 1'b1;
    step(3);
    check(unit_en, 1'b0, "idle gating");
    idle_gate <= 1'b0;
    step(3);
    check(unit_en, 1'b1, "units run");
    $display("test regs done");
  endtask : t_regs

  task automatic t_light();
    int i;
    enter(1'b0, 32'h1);
    step(1);
    check(unit_en, 1'b0, "units off");
    check(tb_en, 1'b1, "time base on");
    snoop_req <= 1'b1;
    for (i = 0; i < 10 && lp_if_inst.clocks_gated !== 1'b0; i++) step(1);
    check(snoop_en, 1'b1, "snoop window");
    snoop_req <= 1'b0;
    for (i = 0; i < 10 && lp_if_inst.clocks_gated !== 1'b1; i++) step(1);
    check(lp_if_inst.clocks_gated, 1'b1, "regated");
    wake_q <= 4'h1;
    step(2);
    check({lp_if_inst.quiesce_done, lp_if_inst.clocks_gated, pd_bit}, 3'h0, "wake");
    wake_q <= 4'h0;
    step(4);
    check(lp_if_inst.light_req, 1'b0, "request gone");
    $display("test light done");
  endtask : t_light

  task automatic t_deep();
    int k;
    for (k = 0; k < 4; k++) begin
      enter(1'b1, 32'h1);
      step(1);
      check({tb_en, unit_en, snoop_en, pll_run}, 4'h1, "deep clocks");
      snoop_req <= 1'b1;
      dec_irq <= 1'b1;
      step(6);
      check(lp_if_inst.clocks_gated, 1'b1, "deep holds");
      snoop_req <= 1'b0;
      dec_irq <= 1'b0;
      wake_q <= 4'h1 << k;
      step(2);
      check({lp_if_inst.quiesce_done, lp_if_inst.clocks_gated, pd_bit}, 3'h0, "wake");
      wake_q <= 4'h0;
      step(4);
    end
    $display("test deep done");
  endtask : t_deep

  task automatic t_pll();
    logic [31:0] r;
    int i;
    enter(1'b1, 32'h3);
    for (i = 0; i < 20 && pll_run !== 1'b0; i++) step(1);
    check(lp_if_inst.pll_cfg, PLL_OFF_CFG, "off code");
    check({pll_run, tick}, 2'h0, "pll off");
    wb(1'b1, CTRL_OFS, 32'h10, 4'h1, r);
    for (i = 0; i < 20 && lp_if_inst.hreset_n !== 1'b0; i++) step(1);
    check(lp_if_inst.pll_cfg, PLLCFG_RESET, "cfg restored");
    for (i = 0; i < 40 && lp_if_inst.hreset_n !== 1'b1; i++) step(1);
    for (i = 0; i < 40 && unit_en !== 1'b1; i++) step(1);
    check(i >= INIT_N, 1'b1, "init period");
    check({pll_run, pd_bit}, 2'h2, "pll back");
    $display("test pll done");
  endtask : t_pll

  task automatic t_freq();
    logic [31:0] r;
    logic [5:0] e;
    logic [9:0] tab [7] = '{10'h010, 10'h108, 10'h204, 10'h304, 10'h048, 10'h084, 10'h1d0};
    int k;
    int n;
    for (k = 0; k < 7; k++) begin
      e = tab[k][5:0];
      wb(1'b1, CTRL_OFS, {28'h0, tab[k][7:6], 2'h0}, 4'h1, r);
      step(3);
      div_bits <= tab[k][9:8];
      step(2);
      check(ratio, e, "ratio");
      n = 0;
      repeat (8) begin
        step(1);
        n += int'(tick);
      end
      check(n, e >> 1, "tick rate");
      check(lp_if_inst.ack_delay, (e < 6'h06) ? 2'h2 : (e < 6'h0a) ? 2'h1 : 2'h0, "need");
      check(aack, (e < 6'h06) ? 2'h2 : (e < 6'h0a) ? 2'h1 : 2'h0, "aack");
      div_bits <= 2'h0;
      wb(1'b1, CTRL_OFS, 32'h0, 4'h1, r);
      step(4);
    end
    $display("test freq done");
  endtask : t_freq

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test

  // ====================
  // Clock, timeout, sequence
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  initial begin
    rst_i = 1'b1;
    pipe_empty = 1'b1;
    {pd_set, light_sel, deep_sel, idle_gate, dec_irq, snoop_req, wb_cyc, wb_stb, wb_we} = '0;
    {wb_adr, wb_sel, wb_dat_w, div_bits, wake_q} = '0;
    step(3);
    rst_i <= 1'b0;
    step(1);
    t_regs();
    t_light();
    t_deep();
    t_pll();
    t_freq();
    stop_test();
  end
endmodule : core_lowpower_handshake_tb_top
